// [rtl/dlp_pkg.sv]
// shared constants and carrier types for the dual log pot serial slave
package dlp_pkg;

  // ----------------------------------------------------------------
  // wiper geometry
  // ----------------------------------------------------------------
  localparam int WIPER_W = 6;
  localparam logic [5:0] MUTE_POS = 6'h21;

  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_TYPE_MSB = 7;
  localparam int CMD_TYPE_LSB = 4;
  localparam int CMD_SEL_MSB = 3;
  localparam int CMD_SEL_LSB = 1;
  localparam int CMD_RW_BIT = 0;

  // ----------------------------------------------------------------
  // wiper data byte: channel tag in bits 7:6, position in bits 5:0
  // ----------------------------------------------------------------
  localparam int DATA_TAG_MSB = 7;
  localparam int DATA_TAG_LSB = 6;
  localparam logic [1:0] TAG_CH0 = 2'h0;
  localparam logic [1:0] TAG_CH1 = 2'h1;

  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_CMD_ACK, S_WR_DATA, S_WR_ACK, S_RD_DATA, S_RD_ACK,
    S_IGNORE
  } dlp_state_e;

  // one wiper update handed from the link domain to the system domain
  typedef struct packed {
    logic tog;
    logic [WIPER_W-1:0] value;
  } dlp_wr_s;

  // link-side protocol state, registered on rising serial clock
  typedef struct packed {
    dlp_state_e state;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic idx;
    logic start_ack;
    logic stop_ack;
    logic [WIPER_W-1:0] shadow0;
    logic [WIPER_W-1:0] shadow1;
    dlp_wr_s wr0;
    dlp_wr_s wr1;
  } dlp_link_s;

  typedef struct packed {
    logic prev;
    logic [WIPER_W-1:0] wiper;
  } dlp_pot_s;

endpackage

// [rtl/dlp_pot_slave.sv]
// two-wire serial slave with two wiper registers
`timescale 1ns/100ps

// What this block does
// - two independent channels, each own wiper register
// - each wiper position held in six bits
// - thirty-four taps, top one is mute
// - both wipers start at mute after reset
// - enable pin high makes link ignored entirely
// - sample on rising clock, drive on falling
// - data line only pulled low or released
// - three select pins set the bus address
// - device is slave; master makes clock, conditions
// - command byte: type, select bits, direction bit
// - read gives channel 0 then 1; NACK ends
// - all bytes travel most significant bit first
// - acknowledge every received byte on ninth clock, except a command byte for another address
module dlp_pot_slave
  import dlp_pkg::*;
#(
  // device type code of the command byte; value is arbitrary
  parameter logic [3:0] DEV_TYPE_CODE = 4'ha
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ce_n,
  input wire logic device_select_bit0,
  input wire logic device_select_bit1,
  input wire logic device_select_bit2,
  output logic [WIPER_W-1:0] wiper_terminal_ch0,
  output logic [WIPER_W-1:0] wiper_terminal_ch1
);

  // ----------------------------------------------------------------
  // link-side reset and pins
  // ----------------------------------------------------------------
  logic rst_link;
  logic [2:0] sel_pins;
  logic [2:0] sel_sync;
  logic sda_g;
  logic start_tog;
  logic stop_tog;

  dlp_sync2 #(.W(1)) u_rst_sync (
    .clk(scl_clk),
    .d(srst),
    .q(rst_link)
  );

  assign sel_pins = {device_select_bit2, device_select_bit1,
                     device_select_bit0};

  // address straps are slow levels, so a plain synchroniser suffices
  dlp_sync2 #(.W(3)) u_sel_sync (
    .clk(scl_clk),
    .d(sel_pins),
    .q(sel_sync)
  );

  // a disabled port sees an idle data line
  assign sda_g = sda_in | ce_n;

  // ----------------------------------------------------------------
  // start and stop detection
  // ----------------------------------------------------------------
  // conditions are data edges while the clock is high, so they can only
  // be seen by flops clocked on the data line itself; the toggles are
  // read at the next rising clock, long after they settled
  always_ff @(negedge sda_g or posedge rst_link) begin
    if (rst_link) begin
      start_tog <= 1'b0;
    end else if (scl_clk) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_g or posedge rst_link) begin
    if (rst_link) begin
      stop_tog <= 1'b0;
    end else if (scl_clk) begin
      stop_tog <= ~stop_tog;
    end
  end

  // ----------------------------------------------------------------
  // protocol state machine on the rising serial clock
  // ----------------------------------------------------------------
  dlp_link_s st;
  dlp_link_s next_st;
  logic [7:0] rx_byte;
  logic addr_hit;
  logic [WIPER_W-1:0] rx_pos;
  logic [7:0] tx_byte;

  assign rx_byte = {st.sh[6:0], sda_in};
  assign addr_hit =
    (rx_byte[CMD_TYPE_MSB:CMD_TYPE_LSB] == DEV_TYPE_CODE) &&
    (rx_byte[CMD_SEL_MSB:CMD_SEL_LSB] == sel_sync);
  // anything past the mute tap is held at mute
  assign rx_pos = (st.sh[WIPER_W-1:0] > MUTE_POS) ?
                  MUTE_POS : st.sh[WIPER_W-1:0];
  assign tx_byte = st.idx ? {TAG_CH1, st.shadow1} :
                            {TAG_CH0, st.shadow0};

  always_comb begin
    next_st = st;
    if (ce_n) begin
      next_st.state = S_IDLE;
      next_st.start_ack = start_tog;
      next_st.stop_ack = stop_tog;
    end else if (start_tog != st.start_ack) begin
      // this rising edge already carries the first command bit
      next_st.start_ack = start_tog;
      next_st.stop_ack = stop_tog;
      next_st.state = S_CMD;
      next_st.sh = {7'h00, sda_in};
      next_st.cnt = 3'h1;
    end else if (stop_tog != st.stop_ack) begin
      next_st.stop_ack = stop_tog;
      next_st.state = S_IDLE;
    end else begin
      case (st.state)
        S_CMD: begin
          next_st.sh = rx_byte;
          next_st.cnt = st.cnt + 3'h1;
          if (st.cnt == 3'h7) begin
            if (addr_hit) begin
              next_st.state = S_CMD_ACK;
              next_st.rw = rx_byte[CMD_RW_BIT];
            end else begin
              next_st.state = S_IGNORE;
            end
          end
        end
        S_CMD_ACK: begin
          next_st.cnt = 3'h0;
          next_st.idx = 1'b0;
          next_st.state = st.rw ? S_RD_DATA : S_WR_DATA;
        end
        S_WR_DATA: begin
          next_st.sh = rx_byte;
          next_st.cnt = st.cnt + 3'h1;
          if (st.cnt == 3'h7) begin
            next_st.state = S_WR_ACK;
          end
        end
        S_WR_ACK: begin
          // the acknowledge has just been clocked, so the byte counts
          next_st.cnt = 3'h0;
          next_st.state = S_WR_DATA;
          if (st.sh[DATA_TAG_MSB:DATA_TAG_LSB] == TAG_CH0) begin
            next_st.shadow0 = rx_pos;
            next_st.wr0.value = rx_pos;
            next_st.wr0.tog = ~st.wr0.tog;
          end else if (st.sh[DATA_TAG_MSB:DATA_TAG_LSB] == TAG_CH1) begin
            next_st.shadow1 = rx_pos;
            next_st.wr1.value = rx_pos;
            next_st.wr1.tog = ~st.wr1.tog;
          end
        end
        S_RD_DATA: begin
          next_st.cnt = st.cnt + 3'h1;
          if (st.cnt == 3'h7) begin
            next_st.state = S_RD_ACK;
          end
        end
        S_RD_ACK: begin
          if (!sda_in) begin
            next_st.idx = ~st.idx;
            next_st.cnt = 3'h0;
            next_st.state = S_RD_DATA;
          end else begin
            next_st.state = S_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk) begin
    if (rst_link) begin
      st.state <= S_IDLE;
      st.cnt <= 3'h0;
      st.sh <= 8'h00;
      st.rw <= 1'b0;
      st.idx <= 1'b0;
      st.start_ack <= 1'b0;
      st.stop_ack <= 1'b0;
      st.shadow0 <= MUTE_POS;
      st.shadow1 <= MUTE_POS;
      st.wr0 <= '0;
      st.wr1 <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // data line driver on the falling serial clock
  // ----------------------------------------------------------------
  always_ff @(negedge scl_clk) begin
    if (rst_link || ce_n) begin
      sda_oe <= 1'b0;
    end else begin
      case (st.state)
        S_CMD_ACK, S_WR_ACK: sda_oe <= 1'b1;
        S_RD_DATA: sda_oe <= ~tx_byte[~st.cnt];
        default: sda_oe <= 1'b0;
      endcase
    end
  end

  // open drain: the only level ever driven is low
  assign sda_out = 1'b0;

  // ----------------------------------------------------------------
  // wiper registers in the system domain
  // ----------------------------------------------------------------
  dlp_pot_wiper u_ch0 (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr(st.wr0),
    .wiper(wiper_terminal_ch0)
  );

  dlp_pot_wiper u_ch1 (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr(st.wr1),
    .wiper(wiper_terminal_ch1)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cmd_ack;
    @(posedge scl_clk) disable iff (rst_link)
      (st.state == S_CMD_ACK && !ce_n) |-> sda_oe;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack)
    else $error("command byte not acknowledged");

  property p_wr_ack;
    @(posedge scl_clk) disable iff (rst_link)
      (st.state == S_WR_ACK && !ce_n) |-> sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("data byte not acknowledged");

  property p_disabled_idle;
    @(posedge scl_clk) disable iff (rst_link)
      ce_n |=> st.state == S_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("link active while port disabled");

  property p_miss_ignored;
    @(posedge scl_clk) disable iff (rst_link)
      (!ce_n && st.state == S_CMD && st.cnt == 3'h7 && !addr_hit &&
       start_tog == st.start_ack && stop_tog == st.stop_ack)
      |=> st.state == S_IGNORE ##1 !sda_oe;
  endproperty
  a_miss_ignored: assert property (p_miss_ignored)
    else $error("foreign address was answered");

  property p_read_first_ch0;
    @(posedge scl_clk) disable iff (rst_link || ce_n)
      (st.state == S_CMD_ACK && st.rw &&
       start_tog == st.start_ack && stop_tog == st.stop_ack)
      |=> st.state == S_RD_DATA && !st.idx;
  endproperty
  a_read_first_ch0: assert property (p_read_first_ch0)
    else $error("read did not start with channel 0");

  property p_release_for_ack;
    @(posedge scl_clk) disable iff (rst_link)
      st.state == S_RD_ACK |-> !sda_oe;
  endproperty
  a_release_for_ack: assert property (p_release_for_ack)
    else $error("data line held during master acknowledge");

  property p_msb_first;
    @(posedge scl_clk) disable iff (rst_link || ce_n)
      (st.state == S_RD_DATA && st.cnt == 3'h0) |-> sda_oe == ~tx_byte[7];
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("read byte not sent msb first");

  property p_start_restarts;
    @(posedge scl_clk) disable iff (rst_link)
      (!ce_n && start_tog != st.start_ack)
      |=> st.state == S_CMD && st.cnt == 3'h1;
  endproperty
  a_start_restarts: assert property (p_start_restarts)
    else $error("start did not begin a command byte");

  property p_nack_ends;
    @(posedge scl_clk) disable iff (rst_link || ce_n)
      (st.state == S_RD_ACK && sda_in &&
       start_tog == st.start_ack && stop_tog == st.stop_ack)
      |=> st.state == S_IGNORE;
  endproperty
  a_nack_ends: assert property (p_nack_ends)
    else $error("read went on after not-acknowledge");

  c_read_two: cover property (@(posedge scl_clk) disable iff (rst_link)
    st.state == S_RD_ACK && st.idx && !sda_in);
  c_write: cover property (@(posedge scl_clk) disable iff (rst_link)
    st.state == S_WR_ACK);
  c_miss: cover property (@(posedge scl_clk) disable iff (rst_link)
    st.state == S_IGNORE);

endmodule // dlp_pot_slave

// [rtl/dlp_pot_wiper.sv]
// one wiper position register in the system clock domain
`timescale 1ns/100ps
module dlp_pot_wiper
  import dlp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire dlp_wr_s wr,
  output logic [WIPER_W-1:0] wiper
);
  dlp_pot_s st;
  dlp_pot_s next_st;
  logic tog_sync;
  logic load;

  // value is held stable by the link side until the toggle has crossed
  dlp_sync2 #(.W(1)) u_sync (
    .clk(clk_sys),
    .d(wr.tog),
    .q(tog_sync)
  );

  assign load = tog_sync ^ st.prev;

  always_comb begin
    next_st = st;
    next_st.prev = tog_sync;
    if (load) begin
      next_st.wiper = wr.value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.prev <= 1'b0;
      st.wiper <= MUTE_POS;
    end else begin
      st <= next_st;
    end
  end

  assign wiper = st.wiper;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mute_at_reset;
    @(posedge clk_sys) srst |=> wiper == MUTE_POS;
  endproperty
  a_mute_at_reset: assert property (p_mute_at_reset)
    else $error("wiper not at mute after reset");

  property p_load_value;
    @(posedge clk_sys) disable iff (srst)
      load |=> wiper == $past(wr.value);
  endproperty
  a_load_value: assert property (p_load_value)
    else $error("wiper did not take the received value");

  property p_tap_range;
    @(posedge clk_sys) disable iff (srst) wiper <= MUTE_POS;
  endproperty
  a_tap_range: assert property (p_tap_range)
    else $error("wiper beyond the mute tap");

  c_load: cover property (@(posedge clk_sys) disable iff (srst) load);
endmodule // dlp_pot_wiper

// [rtl/dlp_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/100ps
module dlp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule // dlp_sync2

// [sim/dlp_master.sv]
// behavioural two-wire bus master facing the wiper slave
`timescale 1ns/100ps
module dlp_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // bus idle: clock parked high, data released to the pull-up
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // clock pulses with data released, used around reset and after re-enable
  task automatic pulses(input int n);
    repeat (n) begin
      #15 scl = 1'b0;
      #15 scl = 1'b1;
    end
  endtask

  // also serves as repeated start when entered with clock low
  task automatic start_cond();
    sda_drv = 1'b1;
    #15 scl = 1'b1;
    #15 sda_drv = 1'b0;
    #15 scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    #15 scl = 1'b1;
    #15 sda_drv = 1'b1;
    #15;
  endtask

  // data set while clock low, line sampled at the rising edge
  task automatic bit_xfer(input logic b, output logic s);
    sda_drv = b;
    #15 scl = 1'b1;
    s = sda;
    #15 scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask

  // last byte of a read is answered with a not-acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, s);
  endtask
endmodule // dlp_master

// [sim/tb.sv]
// self-checking bench for the dual wiper serial slave
`timescale 1ns/100ps
module tb;
  import dlp_pkg::*;
  // device type code; value is arbitrary
  localparam logic [3:0] TYPE = 4'h6;
  localparam logic [2:0] PINS = 3'h5;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce_n = 1'b0;
  logic [2:0] sel = PINS;
  logic scl, m_sda, sda_out, sda_oe, sda_line, a;
  logic [5:0] w0, w1;
  logic [7:0] d;
  int bad_count = 0;
  int n_tests = 0;

  always #50 clk_sys = ~clk_sys;
  // pull-up: low when either party pulls down
  assign sda_line = m_sda & ~(sda_oe & ~sda_out);

  dlp_master i_dlp_master (.scl(scl), .sda_drv(m_sda), .sda(sda_line));
  dlp_pot_slave #(.DEV_TYPE_CODE(TYPE)) i_dlp_pot_slave (
    .clk_sys(clk_sys), .srst(srst), .scl_clk(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .ce_n(ce_n),
    .device_select_bit0(sel[0]), .device_select_bit1(sel[1]),
    .device_select_bit2(sel[2]), .wiper_terminal_ch0(w0),
    .wiper_terminal_ch1(w1)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // the master parks the clock high at time zero, which can look like an
  // edge before the constant output has settled; judge only after reset
  always @(posedge scl) begin
    if (!srst) begin
      check("sda_out", {7'h0, sda_out}, 8'h00);
    end
  end

  initial begin
    #2000000;
    bad_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // scenario helpers
  // ----------------------------------------------------------------
  task automatic wr2(input logic [7:0] c, input logic [7:0] d0,
                     input logic [7:0] d1, input logic exp_ack);
    i_dlp_master.start_cond();
    i_dlp_master.send_byte(c, a);
    check("cmd ack", {7'h0, a}, {7'h0, exp_ack});
    i_dlp_master.send_byte(d0, a);
    check("data0 ack", {7'h0, a}, {7'h0, exp_ack});
    i_dlp_master.send_byte(d1, a);
    check("data1 ack", {7'h0, a}, {7'h0, exp_ack});
    i_dlp_master.stop_cond();
  endtask

  // polls under a bound; the cross into clk_sys takes a few cycles
  task automatic wait_wipers(input logic [5:0] e0, input logic [5:0] e1);
    for (int i = 0; i < 40 && (w0 !== e0 || w1 !== e1); i++) begin
      @(negedge clk_sys);
    end
    check("wiper ch0", {2'b00, w0}, {2'b00, e0});
    check("wiper ch1", {2'b00, w1}, {2'b00, e1});
  endtask

  task automatic rd_check(input logic [5:0] e0, input logic [5:0] e1);
    i_dlp_master.start_cond();
    i_dlp_master.send_byte({TYPE, PINS, 1'b1}, a);
    check("read cmd ack", {7'h0, a}, 8'h01);
    i_dlp_master.recv_byte(1'b0, d);
    check("read ch0", d, {TAG_CH0, e0});
    i_dlp_master.recv_byte(1'b1, d);
    check("read ch1", d, {TAG_CH1, e1});
    i_dlp_master.stop_cond();
    check("line idle", {7'h0, sda_line}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (2) @(negedge clk_sys);
    i_dlp_master.pulses(4);
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    i_dlp_master.pulses(3);
    check("reset ch0", {2'b00, w0}, {2'b00, MUTE_POS});
    check("reset ch1", {2'b00, w1}, {2'b00, MUTE_POS});
    check("reset oe", {7'h0, sda_oe}, 8'h00);
  endtask

  task automatic t_write_read();
    wr2({TYPE, PINS, 1'b0}, 8'h05, 8'h54, 1'b1);
    wait_wipers(6'h05, 6'h14);
    rd_check(6'h05, 6'h14);
    // over-range position clamps to mute; unknown tag is acked, dropped
    wr2({TYPE, PINS, 1'b0}, 8'h3f, 8'h81, 1'b1);
    wait_wipers(6'h21, 6'h14);
    rd_check(6'h21, 6'h14);
  endtask

  task automatic t_address();
    for (int s = 0; s < 8; s++) begin
      i_dlp_master.start_cond();
      i_dlp_master.send_byte({TYPE, s[2:0], 1'b0}, a);
      check("select ack", {7'h0, a}, {7'h0, s[2:0] == PINS});
      i_dlp_master.send_byte({5'h00, s[2:0]}, a);
      i_dlp_master.stop_cond();
    end
    wait_wipers(6'h05, 6'h14);
    wr2({TYPE ^ 4'h1, PINS, 1'b0}, 8'h01, 8'h41, 1'b0);
    wait_wipers(6'h05, 6'h14);
  endtask

  task automatic t_disable();
    @(negedge clk_sys);
    ce_n = 1'b1;
    wr2({TYPE, PINS, 1'b0}, 8'h02, 8'h42, 1'b0);
    wait_wipers(6'h05, 6'h14);
    @(negedge clk_sys);
    ce_n = 1'b0;
    i_dlp_master.pulses(2);
    rd_check(6'h05, 6'h14);
  endtask

  initial begin
    t_reset();
    t_write_read();
    t_address();
    t_disable();
    summarize();
  end
endmodule // tb
